// [core/lvq_map.svh]
// offsets, fixed-point positions, field limits and counts of the lattice quantizer
`ifndef LVQ_MAP_SVH
`define LVQ_MAP_SVH
`define LVQ_BAND_DIM     8
`define LVQ_NUM_COEF     64
`define LVQ_FRAC         4
`define LVQ_ONE_Q4       16
`define LVQ_HALF_Q5      16
`define LVQ_Q5           5
`define LVQ_E_MIN        2
`define LVQ_E_MIN_RAW    (`LVQ_E_MIN << (2 * `LVQ_FRAC))
`define LVQ_LOG_BIAS_Q4  144
`define LVQ_RATE_MUL     5
`define LVQ_STEP_INIT    512
`define LVQ_ITERS        10
`define LVQ_TGT_NUM      19
`define LVQ_TGT_DEN      5
`define LVQ_OFF_PER_OCT  40
`define LVQ_MANT_ONE     256
`define LVQ_MANT_SHIFT   8
`define LVQ_BASE_MAX     4
`define LVQ_Q2_SPHERE    1
`define LVQ_Q3_SPHERE    2
`define LVQ_Q4_SPHERE    4
`endif

// [core/lvq_pkg.sv]
// types shared by the lattice quantizer modules
package lvq_pkg;
   typedef logic signed [15:0] lvq_coef_t;
   typedef logic [7:0][15:0]   lvq_nvec_t;
   typedef logic [7:0][12:0]   lvq_lvec_t;
   typedef logic [7:0][23:0]   lvq_svec_t;
   typedef enum logic [2:0] {
      LVQ_S_LOAD   = 3'b000,
      LVQ_S_SEARCH = 3'b001,
      LVQ_S_GAIN   = 3'b010,
      LVQ_S_READ   = 3'b011,
      LVQ_S_PICK   = 3'b100,
      LVQ_S_EMIT   = 3'b101
   } lvq_state_e;
   typedef struct packed {
      logic [2:0]  band;
      logic [3:0]  cb_num;
      logic [1:0]  ext_order;
      logic [8:0]  unary;
      logic [3:0]  unary_len;
      logic [15:0] ext_index;
      lvq_lvec_t   lattice;
      lvq_svec_t   spectrum;
      logic [9:0]  gain_offset;
   } lvq_band_s;
endpackage

// [core/lvq_strm_if.sv]
// valid/ready stream carrying one coded sub-band
`timescale 1ns/1ps
interface lvq_strm_if;
   logic               valid;
   logic               ready;
   lvq_pkg::lvq_band_s data;
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface

// [core/lvq_coef_mem.sv]
// 64-word coefficient store with registered read data
`timescale 1ns/1ps
`include "lvq_map.svh"
module lvq_coef_mem (
   input  wire logic              core_clk, // clock
   input  wire logic              wr_en,    // write strobe
   input  wire logic [5:0]        wr_addr,  // write address
   input  wire lvq_pkg::lvq_coef_t wr_data, // write data
   input  wire logic [5:0]        rd_addr,  // read address
   output lvq_pkg::lvq_coef_t     rd_data   // read data, one cycle late
);
   lvq_pkg::lvq_coef_t mem [`LVQ_NUM_COEF];

   always_ff @(posedge core_clk) begin
      if (wr_en) begin
         mem[wr_addr] <= wr_data;
      end
      rd_data <= mem[rd_addr];
   end
endmodule

// [core/lvq_skid_buf.sv]
// two-entry buffer; output word held in a register, second entry catches stalls
`timescale 1ns/1ps
module lvq_skid_buf (
   input  wire logic core_clk, // clock
   input  wire logic sys_rst,  // async reset, active high
   lvq_strm_if.snk   up,       // filling side
   lvq_strm_if.src   dn        // draining side
);
   lvq_pkg::lvq_band_s head;
   lvq_pkg::lvq_band_s skid;
   logic               head_v;
   logic               skid_v;
   wire                advance = !head_v || dn.ready;

   assign up.ready = !skid_v;
   assign dn.valid = head_v;
   assign dn.data  = head;

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         head   <= '0;
         skid   <= '0;
         head_v <= 1'b0;
         skid_v <= 1'b0;
      end else if (advance) begin
         if (skid_v) begin
            head   <= skid;
            head_v <= 1'b1;
            skid_v <= 1'b0;
         end else begin
            head_v <= up.valid;
            if (up.valid) begin
               head <= up.data;
            end
         end
      end else if (up.valid && !skid_v) begin
         skid   <= up.data;
         skid_v <= 1'b1;
      end
   end
endmodule

// [core/lvq_quantizer.sv]
// gain-shape lattice vector quantizer for 64 coefficients in 8 sub-bands
`timescale 1ns/1ps
`include "lvq_map.svh"
module lvq_quantizer (
   input  wire logic        core_clk,             // 40 MHz clock
   input  wire logic        sys_rst,              // async reset, active high
   input  wire logic        in_valid,             // coefficient strobe
   output logic             in_ready,             // coefficient accepted
   input  wire logic [15:0] in_coef,              // signed coefficient, 4 fraction bits
   input  wire logic [11:0] available_bit_budget, // bits for the frame
   input  wire logic [3:0]  subband_count,        // sub-bands to code, 1..8
   output logic             out_valid,            // coded sub-band present
   input  wire logic        out_ready,            // consumer takes it
   output logic [2:0]       out_band,             // sub-band number
   output logic [3:0]       out_cb_num,           // codebook number
   output logic [1:0]       out_ext_order,        // extension order
   output logic [8:0]       out_unary,            // unary code, last bit sent at lsb
   output logic [3:0]       out_unary_len,        // unary code length
   output logic [15:0]      out_ext_index,        // extension point, 8r bits
   output logic [103:0]     out_lattice,          // lattice point, 8 x 13 bits
   output logic [191:0]     out_spectrum,         // rescaled spectrum, 8 x 24 bits
   output logic [9:0]       out_gain_offset,      // gain offset, 2 fraction bits
   output logic             busy                  // frame in progress
);
   ////////////////////////////////////////////////////////////////////////////
   lvq_pkg::lvq_state_e state;
   logic [5:0]          wr_idx;
   logic [33:0]         energy;
   logic [7:0][9:0]     rate;
   logic [11:0]         budget;
   logic [3:0]          count;
   logic [16:0]         target;
   logic [9:0]          offset;
   logic [9:0]          step;
   logic [3:0]          iter;
   logic [4:0]          shift_k;
   logic [8:0]          mant;
   logic [9:0]          inv_mant;
   logic [2:0]          band;
   logic [3:0]          rd_cnt;
   lvq_pkg::lvq_nvec_t  norm;
   logic [12:0]         used;
   lvq_pkg::lvq_band_s  band_r;
   lvq_pkg::lvq_coef_t  rd_data;
   lvq_strm_if          bq ();
   lvq_strm_if          bo ();

   ////////////////////////////////////////////////////////////////////////////
   function automatic logic [5:0] msb_pos(input logic [33:0] x);
      logic [5:0] p;
      p = '0;
      for (int i = 0; i < 34; i++) begin
         if (x[i]) p = 6'(i);
      end
      return p;
   endfunction

   function automatic lvq_pkg::lvq_lvec_t coset_pt(input lvq_pkg::lvq_nvec_t v,
                                                   input logic odd);
      logic signed [17:0] zq;
      logic signed [17:0] ez;
      logic signed [17:0] eb;
      logic [17:0]        mag;
      logic [17:0]        ab;
      logic signed [12:0] r;
      logic signed [15:0] s;
      logic [2:0]         bi;
      lvq_pkg::lvq_lvec_t y;
      eb = '0;
      ab = '0;
      bi = '0;
      s  = '0;
      y  = '0;
      for (int i = 0; i < 8; i++) begin
         zq = 18'($signed(v[i])) - (odd ? 18'sd16 : 18'sd0);
         mag = zq[17] ? 18'(-zq) : zq;
         r = 13'((mag + 18'(`LVQ_HALF_Q5)) >> `LVQ_Q5);
         if (zq[17]) r = -r;
         y[i] = 13'(r <<< 1);
         ez = zq - 18'($signed(y[i]) <<< `LVQ_Q5);
         mag = ez[17] ? 18'(-ez) : ez;
         if (mag > ab) begin
            ab = mag;
            eb = ez;
            bi = 3'(i);
         end
         s = s + 16'($signed(y[i]));
      end
      if (s[1:0] != 2'b00) begin
         y[bi] = eb[17] ? 13'($signed(y[bi]) - 13'sd2) : 13'($signed(y[bi]) + 13'sd2);
      end
      if (odd) begin
         for (int i = 0; i < 8; i++) y[i] = 13'($signed(y[i]) + 13'sd1);
      end
      return y;
   endfunction

   function automatic logic [39:0] sq_err(input lvq_pkg::lvq_nvec_t v,
                                          input lvq_pkg::lvq_lvec_t y);
      logic signed [18:0] d;
      logic [39:0]        acc;
      acc = '0;
      for (int i = 0; i < 8; i++) begin
         d = 19'($signed(v[i])) - 19'($signed(y[i]) <<< `LVQ_FRAC);
         acc = acc + 40'(d * d);
      end
      return acc;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // energy and rate of the sub-band being loaded
   wire         take       = in_valid && in_ready;
   wire [31:0]  coef_sq    = 32'($signed(in_coef) * $signed(in_coef));
   wire [33:0]  energy_nx  = energy + 34'(coef_sq);
   wire [33:0]  energy_cl  = (energy_nx < 34'(`LVQ_E_MIN_RAW)) ? 34'(`LVQ_E_MIN_RAW)
                                                               : energy_nx;
   wire [5:0]   e_msb      = msb_pos(energy_cl);
   wire [33:0]  e_norm     = energy_cl << (6'd33 - e_msb);
   wire [9:0]   log_q4     = {e_msb, e_norm[32:29]};
   wire [12:0]  rate_q4    = 13'(`LVQ_RATE_MUL) * 13'(log_q4 - 10'(`LVQ_LOG_BIAS_Q4));
   wire [9:0]   rate_q2    = 10'(rate_q4 >> 2);
   wire [12:0]  base_bits  = (available_bit_budget > 12'(subband_count))
                             ? 13'(available_bit_budget - 12'(subband_count)) : 13'd0;
   wire [16:0]  target_nx  = 17'((base_bits * 17'(`LVQ_TGT_NUM)) / 17'(`LVQ_TGT_DEN));

   // bits needed at the trial offset
   wire [9:0]   trial      = offset + step;
   logic [12:0] trial_bits;
   always_comb begin
      trial_bits = '0;
      for (int j = 0; j < 8; j++) begin
         if (4'(j) < count && rate[j] > trial) begin
            trial_bits = trial_bits + 13'(rate[j] - trial);
         end
      end
   end
   wire         keep_step  = 17'(trial_bits) > target;

   // gain two^(offset/40): octave shift plus linear mantissa
   wire [4:0]   k_nx       = 5'(offset / 10'(`LVQ_OFF_PER_OCT));
   wire [5:0]   frac_nx    = 6'(offset % 10'(`LVQ_OFF_PER_OCT));
   wire [8:0]   mant_nx    = 9'(`LVQ_MANT_ONE) - 9'((frac_nx * 10'd16) / 10'd5);
   wire [9:0]   inv_nx     = 10'(`LVQ_MANT_ONE) + 10'((frac_nx * 11'd32) / 11'd5);

   // normalization of a stored coefficient
   wire [5:0]   rd_addr    = {band, rd_cnt[2:0]};
   wire signed [25:0] scaled = 26'($signed(rd_data) * $signed({1'b0, mant}));
   wire signed [25:0] norm_nx = scaled >>> (5'(`LVQ_MANT_SHIFT) + shift_k);

   // point of the two cosets with the larger error, odd on a tie
   wire lvq_pkg::lvq_lvec_t y_even = coset_pt(norm, 1'b0);
   wire lvq_pkg::lvq_lvec_t y_odd  = coset_pt(norm, 1'b1);
   wire [39:0]  e_even     = sq_err(norm, y_even);
   wire [39:0]  e_odd      = sq_err(norm, y_odd);
   wire lvq_pkg::lvq_lvec_t y_sel = (e_even > e_odd) ? y_even : y_odd;

   // sphere of the point and its codebook
   logic [26:0] radius2;
   always_comb begin
      radius2 = '0;
      for (int i = 0; i < 8; i++) begin
         radius2 = radius2 + 27'($signed(y_sel[i]) * $signed(y_sel[i]));
      end
   end
   wire [23:0]  sphere     = 24'(radius2 >> 3);
   wire [23:0]  sphere_r1  = sphere >> 2;
   wire [23:0]  sphere_r2  = sphere >> 4;
   wire         in_base    = sphere <= 24'(`LVQ_Q4_SPHERE);
   wire [3:0]   cb_base    = (sphere == 24'd0) ? 4'd0 :
                             (sphere <= 24'(`LVQ_Q2_SPHERE)) ? 4'd2 :
                             (sphere <= 24'(`LVQ_Q3_SPHERE)) ? 4'd3 : 4'd4;
   wire [1:0]   ext_nx     = in_base ? 2'd0 :
                             (sphere_r1 <= 24'(`LVQ_Q4_SPHERE)) ? 2'd1 : 2'd2;
   wire [23:0]  sphere_ext = (ext_nx == 2'd1) ? sphere_r1 : sphere_r2;
   wire [3:0]   cb_ext     = (sphere_ext <= 24'(`LVQ_Q3_SPHERE))
                             ? 4'(2 * ext_nx + 3) : 4'(2 * ext_nx + 4);
   wire [3:0]   cb_nx      = in_base ? cb_base : cb_ext;

   // extension point: low r bits of each component
   logic [15:0] ext_idx_nx;
   always_comb begin
      ext_idx_nx = '0;
      for (int i = 0; i < 8; i++) begin
         if (ext_nx == 2'd1) ext_idx_nx[i] = y_sel[i][0];
         if (ext_nx == 2'd2) ext_idx_nx[2*i +: 2] = y_sel[i][1:0];
      end
   end

   // unary code of the codebook number
   wire [12:0]  cb_bits    = (cb_nx == 4'd0) ? 13'd1 : 13'(`LVQ_RATE_MUL) * 13'(cb_nx);
   wire [12:0]  bits_left  = 13'(budget) - used;
   wire         last_band  = 4'(band) == count - 4'd1;
   wire         drop_zero  = last_band && cb_nx != 4'd0
                             && bits_left == cb_bits - 13'd1;
   wire [8:0]   ones       = (cb_nx == 4'd0) ? 9'd0
                             : 9'((10'd1 << (cb_nx - 4'd1)) - 10'd1);
   wire [8:0]   unary_nx   = drop_zero ? ones : 9'(ones << 1);
   wire [3:0]   ulen_nx    = (cb_nx == 4'd0) ? 4'd1 :
                             drop_zero ? cb_nx - 4'd1 : cb_nx;

   // rescaled spectrum of the chosen point
   lvq_pkg::lvq_svec_t spec_nx;
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         spec_nx[i] = 24'((48'($signed(y_sel[i]) * $signed({1'b0, inv_mant}))
                          <<< shift_k) >>> (`LVQ_MANT_SHIFT - `LVQ_FRAC));
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   assign in_ready = state == lvq_pkg::LVQ_S_LOAD;
   assign busy     = state != lvq_pkg::LVQ_S_LOAD || wr_idx != 6'd0;
   assign bq.valid = state == lvq_pkg::LVQ_S_EMIT;
   assign bq.data  = band_r;

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         state    <= lvq_pkg::LVQ_S_LOAD;
         wr_idx   <= '0;
         energy   <= '0;
         rate     <= '0;
         budget   <= '0;
         count    <= '0;
         target   <= '0;
         offset   <= '0;
         step     <= '0;
         iter     <= '0;
         shift_k  <= '0;
         mant     <= '0;
         inv_mant <= '0;
         band     <= '0;
         rd_cnt   <= '0;
         norm     <= '0;
         used     <= '0;
         band_r   <= '0;
      end else begin
         case (state)
            lvq_pkg::LVQ_S_LOAD: begin
               if (take) begin
                  wr_idx <= wr_idx + 6'd1;
                  energy <= (wr_idx[2:0] == 3'd7) ? 34'd0 : energy_nx;
                  if (wr_idx == 6'd0) begin
                     budget <= available_bit_budget;
                     count  <= subband_count;
                     target <= target_nx;
                  end
                  if (wr_idx[2:0] == 3'd7) rate[wr_idx[5:3]] <= rate_q2;
                  if (wr_idx == 6'd63) begin
                     state  <= lvq_pkg::LVQ_S_SEARCH;
                     offset <= '0;
                     step   <= 10'(`LVQ_STEP_INIT);
                     iter   <= '0;
                  end
               end
            end
            lvq_pkg::LVQ_S_SEARCH: begin
               if (keep_step) offset <= trial;
               step <= step >> 1;
               iter <= iter + 4'd1;
               if (iter == 4'(`LVQ_ITERS - 1)) state <= lvq_pkg::LVQ_S_GAIN;
            end
            lvq_pkg::LVQ_S_GAIN: begin
               shift_k  <= k_nx;
               mant     <= mant_nx;
               inv_mant <= inv_nx;
               band     <= '0;
               rd_cnt   <= '0;
               used     <= '0;
               state    <= lvq_pkg::LVQ_S_READ;
            end
            lvq_pkg::LVQ_S_READ: begin
               rd_cnt <= rd_cnt + 4'd1;
               if (rd_cnt != 4'd0) norm[rd_cnt[2:0] - 3'd1] <= 16'(norm_nx);
               if (rd_cnt == 4'd8) state <= lvq_pkg::LVQ_S_PICK;
            end
            lvq_pkg::LVQ_S_PICK: begin
               band_r.band        <= band;
               band_r.cb_num      <= cb_nx;
               band_r.ext_order   <= ext_nx;
               band_r.unary       <= unary_nx;
               band_r.unary_len   <= ulen_nx;
               band_r.ext_index   <= ext_idx_nx;
               band_r.lattice     <= y_sel;
               band_r.spectrum    <= spec_nx;
               band_r.gain_offset <= offset;
               used               <= used + cb_bits;
               state              <= lvq_pkg::LVQ_S_EMIT;
            end
            lvq_pkg::LVQ_S_EMIT: begin
               if (bq.ready) begin
                  rd_cnt <= '0;
                  band   <= band + 3'd1;
                  state  <= (4'(band) + 4'd1 >= count) ? lvq_pkg::LVQ_S_LOAD
                                                       : lvq_pkg::LVQ_S_READ;
                  if (4'(band) + 4'd1 >= count) wr_idx <= '0;
               end
            end
            default: state <= lvq_pkg::LVQ_S_LOAD;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   lvq_coef_mem u_mem (
      .core_clk (core_clk),
      .wr_en    (take),
      .wr_addr  (wr_idx),
      .wr_data  (lvq_pkg::lvq_coef_t'(in_coef)),
      .rd_addr  (rd_addr),
      .rd_data  (rd_data)
   );

   lvq_skid_buf u_buf (
      .core_clk (core_clk),
      .sys_rst  (sys_rst),
      .up       (bq.snk),
      .dn       (bo.src)
   );

   assign bo.ready        = out_ready;
   assign out_valid       = bo.valid;
   assign out_band        = bo.data.band;
   assign out_cb_num      = bo.data.cb_num;
   assign out_ext_order   = bo.data.ext_order;
   assign out_unary       = bo.data.unary;
   assign out_unary_len   = bo.data.unary_len;
   assign out_ext_index   = bo.data.ext_index;
   assign out_lattice     = bo.data.lattice;
   assign out_spectrum    = bo.data.spectrum;
   assign out_gain_offset = bo.data.gain_offset;
endmodule

// [testbench/lvq_quantizer_checker.sv]
// port assertions for the lattice quantizer
`timescale 1ns/1ps
module lvq_quantizer_checker (
   input wire logic         core_clk,      // clock
   input wire logic         sys_rst,       // async reset
   input wire logic         in_ready,      // load state
   input wire logic         out_valid,     // band present
   input wire logic         out_ready,     // band taken
   input wire logic [2:0]   out_band,      // band number
   input wire logic [3:0]   out_cb_num,    // codebook number
   input wire logic [1:0]   out_ext_order, // extension order
   input wire logic [8:0]   out_unary,     // unary code
   input wire logic [3:0]   out_unary_len, // unary length
   input wire logic [15:0]  out_ext_index, // extension point
   input wire logic [103:0] out_lattice    // lattice point
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (sys_rst);
   // same parity everywhere, sum a multiple of four
   function automatic logic re8_ok(input logic [103:0] v);
      logic [12:0] s;
      logic        all_odd;
      logic        all_even;
      s = 13'h0;
      all_odd = 1'b1;
      all_even = 1'b1;
      for (int i = 0; i < 8; i++) begin
         s = s + v[13*i +: 13];
         all_odd = all_odd & v[13*i];
         all_even = all_even & ~v[13*i];
      end
      return (s[1:0] == 2'b00) && (all_odd || all_even);
   endfunction
   wire logic       lat_ok = re8_ok(out_lattice);
   wire logic [1:0] ord = (out_cb_num <= 4'h4) ? 2'h0 : (out_cb_num <= 4'h6) ? 2'h1 : 2'h2;
   wire logic [8:0] one_sh = 9'h1 << out_unary_len;
   logic [2:0] last_band;
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) last_band <= 3'h7;
      else if (out_valid && out_ready) last_band <= out_band;
   end
   property p_hold;
      out_valid && !out_ready |=> out_valid && $stable(out_band) && $stable(out_lattice);
   endproperty
   a_hold: assert property (p_hold) else $error("band changed while stalled");
   property p_seq;
      out_valid && out_ready |-> out_band == last_band + 3'h1 || out_band == 3'h0;
   endproperty
   a_seq: assert property (p_seq) else $error("bands out of order");
   property p_cb_legal;
      out_valid |-> out_cb_num != 4'h1 && out_cb_num <= 4'h8;
   endproperty
   a_cb_legal: assert property (p_cb_legal) else $error("illegal codebook number");
   property p_ext_order;
      out_valid |-> out_ext_order == ord;
   endproperty
   a_ext_order: assert property (p_ext_order) else $error("wrong extension order");
   property p_ext_zero;
      out_valid && out_ext_order == 2'h0 |-> out_ext_index == 16'h0;
   endproperty
   a_ext_zero: assert property (p_ext_zero) else $error("extension index on base");
   property p_unary_len;
      out_valid |-> out_unary_len == ((out_cb_num == 4'h0) ? 4'h1 : out_cb_num)
         || (out_cb_num != 4'h0 && out_unary_len == out_cb_num - 4'h1);
   endproperty
   a_unary_len: assert property (p_unary_len) else $error("unary length wrong");
   property p_unary_val;
      out_valid |-> out_unary == ((out_cb_num == 4'h0) ? 9'h0
         : (out_unary_len == out_cb_num) ? one_sh - 9'h2 : one_sh - 9'h1);
   endproperty
   a_unary_val: assert property (p_unary_val) else $error("unary code wrong");
   property p_lattice;
      out_valid |-> lat_ok;
   endproperty
   a_lattice: assert property (p_lattice) else $error("point not on lattice");
   property p_first;
      $fell(in_ready) && !out_valid |-> !in_ready [*8] ##[12:16] (out_valid && out_band == 3'h0);
   endproperty
   a_first: assert property (p_first) else $error("first band late or early");
endmodule
bind lvq_quantizer lvq_quantizer_checker chk (
   .core_clk(core_clk), .sys_rst(sys_rst), .in_ready(in_ready), .out_valid(out_valid),
   .out_ready(out_ready), .out_band(out_band), .out_cb_num(out_cb_num),
   .out_ext_order(out_ext_order), .out_unary(out_unary), .out_unary_len(out_unary_len),
   .out_ext_index(out_ext_index), .out_lattice(out_lattice));

// [testbench/lvq_pack_model.sv]
// downstream packer: accepts bands, stalls at random lengths
`timescale 1ns/1ps
module lvq_pack_model (
   input  wire logic core_clk,  // clock
   input  wire logic sys_rst,   // async reset
   input  wire logic stall_en,  // allow stalls
   output logic      out_ready  // band accept
);
   int seed = 29569;
   int hold = 0;
   initial out_ready = 1'b0;
   always @(posedge core_clk) begin
      #1;
      if (sys_rst) out_ready = 1'b0;
      else if (hold > 0) begin
         hold--;
         out_ready = 1'b0;
      end else if (stall_en && ($random(seed) & 3) == 0) begin
         hold = $unsigned($random(seed)) % 24;
         out_ready = 1'b0;
      end else out_ready = 1'b1;
   end
endmodule

// [testbench/lattice_vector_quantizer_tb_top.sv]
// self-checking bench for the lattice quantizer
`timescale 1ns/1ps
module lattice_vector_quantizer_tb_top;
   logic               core_clk, sys_rst, in_valid, stall_en;
   logic [15:0]        in_coef;
   logic [11:0]        available_bit_budget;
   logic [3:0]         subband_count;
   wire logic          in_ready, out_valid, out_ready, busy;
   wire logic [2:0]    out_band;
   wire logic [3:0]    out_cb_num, out_unary_len;
   wire logic [1:0]    out_ext_order;
   wire logic [8:0]    out_unary;
   wire logic [15:0]   out_ext_index;
   wire logic [103:0]  out_lattice;
   wire logic [191:0]  out_spectrum;
   wire logic [9:0]    out_gain_offset;
   int                 n_mismatch = 0, compares = 0, seed = 29569;
   lvq_pkg::lvq_band_s exp_q[$];
   lvq_pkg::lvq_band_s got;
   lvq_quantizer dut (.core_clk(core_clk), .sys_rst(sys_rst), .in_valid(in_valid),
      .in_ready(in_ready), .in_coef(in_coef), .available_bit_budget(available_bit_budget),
      .subband_count(subband_count), .out_valid(out_valid), .out_ready(out_ready),
      .out_band(out_band), .out_cb_num(out_cb_num), .out_ext_order(out_ext_order),
      .out_unary(out_unary), .out_unary_len(out_unary_len), .out_ext_index(out_ext_index),
      .out_lattice(out_lattice), .out_spectrum(out_spectrum),
      .out_gain_offset(out_gain_offset), .busy(busy));
   lvq_pack_model pack (.core_clk(core_clk), .sys_rst(sys_rst), .stall_en(stall_en),
      .out_ready(out_ready));
   ////////////////////////////////////////////////////////////////////////////////
   // patterns: 0 all zero, 1 all 1.0, 2 only first at 4.0, 3 only first at 8.0
   function automatic logic [15:0] coef_of(input int p, input int i);
      return (p == 1) ? 16'h0010 : (p >= 2 && i == 0) ? ((p == 2) ? 16'h0040 : 16'h0080)
                                                        : 16'h0000;
   endfunction
   function automatic logic [12:0] lat_of(input int p, input int i);
      return (p == 1) ? 13'h0002 : (p >= 2 && i == 0) ? ((p == 2) ? 13'h0003 : 13'h0007)
                                                        : 13'h1fff;
   endfunction
   task automatic check(input string name, input logic [191:0] seen, input logic [191:0] exp);
      compares++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic give_verdict();
      $display("compares %0d n_mismatch %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task automatic run_frame(input int f);
      int                 pat[8];
      int                 cnt, used, n;
      logic               ok;
      lvq_pkg::lvq_band_s e;
      cnt = (f == 0) ? 3 : 8;
      stall_en = (f >= 2);
      used = 0;
      n = 0;
      for (int j = 0; j < 8; j++) pat[j] = $unsigned($random(seed)) % 3;
      if (f == 0) pat[1] = 3;
      for (int j = 0; j < cnt; j++) begin
         n = (pat[j] == 0) ? 2 : (pat[j] == 1) ? 4 : (pat[j] == 2) ? 3 : 5;
         e = '0;
         e.band = 3'(j);
         e.cb_num = 4'(n);
         e.unary_len = 4'(n);
         e.unary = (9'h1 << n) - 9'h2;
         e.ext_order = (n > 4) ? 2'h1 : 2'h0;
         e.ext_index = (n > 4) ? 16'h00ff : 16'h0000;
         if (j == cnt - 1 && f[0]) begin
            e.unary_len = 4'(n - 1);
            e.unary = (9'h1 << (n - 1)) - 9'h1;
         end
         for (int i = 0; i < 8; i++) begin
            e.lattice[i] = lat_of(pat[j], i);
            e.spectrum[i] = {{7{e.lattice[i][12]}}, e.lattice[i], 4'h0};
         end
         if (j < cnt - 1) used += 5 * n;
         exp_q.push_back(e);
      end
      subband_count = 4'(cnt);
      available_bit_budget = (f == 0) ? 12'h0c8 : 12'(used + 5 * n - (f[0] ? 1 : 0));
      for (int k = 0; k < 64; k++) begin
         in_valid = 1'b1;
         in_coef = coef_of(pat[k / 8], k % 8);
         do begin
            @(negedge core_clk);
            ok = in_ready;
            @(posedge core_clk);
            #1;
         end while (ok !== 1'b1);
      end
      in_valid = 1'b0;
      for (int w = 0; w < 3000 && exp_q.size() > 0; w++) @(posedge core_clk);
      #1;
      check("bands left", exp_q.size(), 0);
      check("busy", busy, 1'b0);
      $display("test frame %0d done", f);
   endtask
   always @(posedge core_clk) begin
      if (out_valid === 1'b1 && out_ready === 1'b1) begin
         if (exp_q.size() == 0) check("extra band", 1, 0);
         else begin
            got = exp_q.pop_front();
            check("band", out_band, got.band);
            check("cb_num", out_cb_num, got.cb_num);
            check("ext_order", out_ext_order, got.ext_order);
            check("unary", out_unary, got.unary);
            check("unary_len", out_unary_len, got.unary_len);
            check("ext_index", out_ext_index, got.ext_index);
            check("lattice", out_lattice, got.lattice);
            check("spectrum", out_spectrum, got.spectrum);
            check("gain_offset", out_gain_offset, got.gain_offset);
         end
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      core_clk = 1'b0;
      forever #12.5 core_clk = ~core_clk;
   end
   initial begin
      sys_rst = 1'b1;
      in_valid = 1'b0;
      in_coef = 16'h0000;
      available_bit_budget = 12'h000;
      subband_count = 4'h0;
      stall_en = 1'b0;
      repeat (12) @(posedge core_clk);
      #1;
      sys_rst = 1'b0;
      for (int f = 0; f < 4; f++) run_frame(f);
      give_verdict();
   end
   initial begin
      repeat (20000) @(posedge core_clk);
      n_mismatch++;
      $display("[ERR] watchdog expected finish seen hang");
      give_verdict();
   end
endmodule
